// ==== core/cst_pkg.sv ====
// shared constants for the comparator status and threshold block
package cst_pkg;
   // -------------------------------------------------------------
   // geometry
   // -------------------------------------------------------------
   localparam int CST_NCMP = 4;
   localparam int CST_DATA_W = 32;
   localparam int CST_REG_W = 8;
   localparam int CST_ADDR_W = 18;
   localparam int CST_FILT_CYCLES = 16;
   // -------------------------------------------------------------
   // register indices; byte address is four times the index
   // -------------------------------------------------------------
   localparam logic [15:0] CST_IDX_THR = 16'hA03B;
   localparam logic [15:0] CST_IDX_STAT = 16'hA03D;
   localparam logic [15:0] CST_IDX_CTRL = 16'hA040;
   localparam logic [15:0] CST_IDX_MASK = 16'hA041;
   localparam logic [CST_ADDR_W-1:0] CST_ADDR_THR = {CST_IDX_THR, 2'h0};
   localparam logic [CST_ADDR_W-1:0] CST_ADDR_STAT = {CST_IDX_STAT, 2'h0};
   localparam logic [CST_ADDR_W-1:0] CST_ADDR_CTRL = {CST_IDX_CTRL, 2'h0};
   localparam logic [CST_ADDR_W-1:0] CST_ADDR_MASK = {CST_IDX_MASK, 2'h0};
   // -------------------------------------------------------------
   // field positions and reset values
   // -------------------------------------------------------------
   localparam int CST_FLAG_LO = 4;
   localparam int CST_FLAG_HI = 7;
   localparam int CST_LIVE_LO = 0;
   localparam int CST_LIVE_HI = 3;
   localparam int CST_STRB_LANE0 = 0;
   localparam logic [7:0] CST_THR_RST = 8'h00;
   localparam logic [7:0] CST_STAT_RST = 8'h00;
   localparam logic [7:0] CST_CTRL_RST = 8'h00;
   localparam logic [7:0] CST_MASK_RST = 8'h00;
   localparam logic [1:0] CST_RESP_OKAY = 2'h0;
   localparam logic [1:0] CST_RESP_DECERR = 2'h3;
endpackage : cst_pkg

// ==== core/cst_flag.sv ====
// one sticky interrupt flag, set by hardware, cleared by software
`timescale 1ns/100ps
module cst_flag (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // set and clear
   input wire logic set,
   input wire logic clr,
   // flag
   output logic flag
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag <= 1'b0;
      end else if (set) begin
         // set wins so a toggle landing on a clear is not lost
         flag <= 1'b1;
      end else if (clr) begin
         flag <= 1'b0;
      end
   end
endmodule : cst_flag

// ==== core/cst_chan.sv ====
// one comparator lane: synchroniser, polarity, filter, enable gate
`timescale 1ns/100ps
module cst_chan import cst_pkg::*; #(
   parameter int FILT_LEN = CST_FILT_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // analog side
   input wire logic raw_in,
   // controls
   input wire logic enable,
   input wire logic invert,
   input wire logic filter_on,
   // status
   output logic live_out
);
   localparam int CW = $clog2(FILT_LEN);
   logic sync1;
   logic sync2;
   logic pol;
   logic filt;
   logic [CW-1:0] cnt;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
      end
   end

   assign pol = sync2 ^ invert;

   // filter tracks directly while off, so switching it on is clean
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         filt <= 1'b0;
         cnt <= '0;
      end else if (!filter_on || pol == filt) begin
         filt <= pol;
         cnt <= '0;
      end else if (cnt == CW'(FILT_LEN - 1)) begin
         filt <= pol;
         cnt <= '0;
      end else begin
         cnt <= cnt + CW'(1);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         live_out <= 1'b0;
      end else begin
         live_out <= enable & filt;
      end
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   logic [5:0] stable_len;
   always_ff @(posedge aclk) begin
      if (!aresetn || $changed(pol) || !filter_on) begin
         stable_len <= '0;
      end else if (stable_len != 6'h3F) begin
         stable_len <= stable_len + 6'h01;
      end
   end

   AST_FILTER_HOLD: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (filter_on && $past(filter_on) && $changed(filt))
      |-> stable_len >= 6'(FILT_LEN - 1))
      else $error("filtered output moved before input held long enough");
   // live output lags the polarity stage by two edges: filter, then gate
   AST_POLARITY: assert property (
      @(posedge aclk) disable iff (!aresetn)
      (!filter_on && $past(!filter_on) && enable)
      |=> live_out == $past(sync2 ^ invert, 2))
      else $error("live output does not follow polarity setting");
endmodule : cst_chan

// ==== core/cst_top.sv ====
// comparator status, interrupt flags and threshold code behind AXI4-Lite
//
// How it works
// - threshold register, eight bits, resets to zero
// - threshold code drives DAC linearly, 0 to 1.5V
// - same code also drives DAC voltage output
// - status register: flags high, live/filter bits low
// - live output toggle while enabled sets flag
// - filter needs sixteen stable clocks before update
// - interrupt raised only for allowed comparators
// - polarity bit inverts comparator output
`timescale 1ns/100ps
module cst_top import cst_pkg::*; #(
   parameter int NCMP = CST_NCMP,
   parameter int FILT_LEN = CST_FILT_CYCLES
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [CST_ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [CST_DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [CST_ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [CST_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // analog comparators
   input wire logic [NCMP-1:0] cmp_raw,
   output logic [NCMP-1:0] cmp_enable,
   // threshold dac
   output logic [CST_REG_W-1:0] threshold_level_two,
   output logic [CST_REG_W-1:0] dac_level,
   // interrupt
   output logic irq
);
   // -------------------------------------------------------------
   // register state
   // -------------------------------------------------------------
   logic [CST_REG_W-1:0] threshold_level_two_reg;
   logic [NCMP-1:0] filter_on;
   logic [NCMP-1:0] invert;
   logic [NCMP-1:0] irq_allow;
   logic [NCMP-1:0] live;
   logic [NCMP-1:0] live_d;
   logic [NCMP-1:0] flags;
   logic [NCMP-1:0] flag_set;
   logic [NCMP-1:0] flag_clr;
   logic [CST_REG_W-1:0] status_view;

   // -------------------------------------------------------------
   // write channel state
   // -------------------------------------------------------------
   logic aw_held;
   logic w_held;
   logic [CST_ADDR_W-1:0] aw_addr;
   logic [CST_REG_W-1:0] w_data;
   logic w_lane0;
   logic wr_fire;
   logic wr_ok;
   logic wr_mapped;

   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_ok = wr_fire && w_lane0;
   assign wr_mapped = aw_addr == CST_ADDR_THR || aw_addr == CST_ADDR_STAT
      || aw_addr == CST_ADDR_CTRL || aw_addr == CST_ADDR_MASK;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         s_axi_awready <= 1'b0;
         aw_addr <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         s_axi_awready <= 1'b0;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
         s_axi_awready <= 1'b1;
      end else if (!aw_held) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         s_axi_wready <= 1'b0;
         w_data <= '0;
         w_lane0 <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         s_axi_wready <= 1'b0;
         w_data <= s_axi_wdata[CST_REG_W-1:0];
         w_lane0 <= s_axi_wstrb[CST_STRB_LANE0];
      end else if (wr_fire) begin
         w_held <= 1'b0;
         s_axi_wready <= 1'b1;
      end else if (!w_held) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CST_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? CST_RESP_OKAY : CST_RESP_DECERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // software registers
   // -------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         threshold_level_two_reg <= CST_THR_RST;
      end else if (wr_ok && aw_addr == CST_ADDR_THR) begin
         threshold_level_two_reg <= w_data;
      end
   end

   // the dac is linear in the code, so the code is passed untouched
   assign threshold_level_two = threshold_level_two_reg;
   assign dac_level = threshold_level_two_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         filter_on <= CST_STAT_RST[CST_LIVE_HI:CST_LIVE_LO];
      end else if (wr_ok && aw_addr == CST_ADDR_STAT) begin
         filter_on <= w_data[CST_LIVE_HI:CST_LIVE_LO];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_enable <= CST_CTRL_RST[CST_LIVE_HI:CST_LIVE_LO];
         invert <= CST_CTRL_RST[CST_FLAG_HI:CST_FLAG_LO];
      end else if (wr_ok && aw_addr == CST_ADDR_CTRL) begin
         cmp_enable <= w_data[CST_LIVE_HI:CST_LIVE_LO];
         invert <= w_data[CST_FLAG_HI:CST_FLAG_LO];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_allow <= CST_MASK_RST[CST_FLAG_HI:CST_FLAG_LO];
      end else if (wr_ok && aw_addr == CST_ADDR_MASK) begin
         irq_allow <= w_data[CST_FLAG_HI:CST_FLAG_LO];
      end
   end

   // -------------------------------------------------------------
   // comparator lanes and flags
   // -------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         live_d <= '0;
      end else begin
         live_d <= live;
      end
   end

   // a forced-low edge on disable is not an event: enable is already 0
   assign flag_set = (live ^ live_d) & cmp_enable;
   assign flag_clr = (wr_ok && aw_addr == CST_ADDR_STAT)
      ? w_data[CST_FLAG_HI:CST_FLAG_LO] : '0;

   for (genvar i = 0; i < NCMP; i++) begin : g_lane
      cst_chan #(.FILT_LEN(FILT_LEN)) u_chan (
         .aclk(aclk),
         .aresetn(aresetn),
         .raw_in(cmp_raw[i]),
         .enable(cmp_enable[i]),
         .invert(invert[i]),
         .filter_on(filter_on[i]),
         .live_out(live[i])
      );
      cst_flag u_flag (
         .aclk(aclk),
         .aresetn(aresetn),
         .set(flag_set[i]),
         .clr(flag_clr[i]),
         .flag(flags[i])
      );
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(flags & irq_allow);
      end
   end

   // -------------------------------------------------------------
   // read channel
   // -------------------------------------------------------------
   assign status_view = {flags, live};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= CST_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= CST_RESP_OKAY;
         s_axi_rdata <= '0;
         unique case (s_axi_araddr)
            CST_ADDR_THR: begin
               s_axi_rdata[CST_REG_W-1:0] <= threshold_level_two_reg;
            end
            CST_ADDR_STAT: begin
               s_axi_rdata[CST_REG_W-1:0] <= status_view;
            end
            CST_ADDR_CTRL: begin
               s_axi_rdata[CST_REG_W-1:0] <= {invert, cmp_enable};
            end
            CST_ADDR_MASK: begin
               s_axi_rdata[CST_FLAG_HI:CST_FLAG_LO] <= irq_allow;
            end
            default: begin
               s_axi_rresp <= CST_RESP_DECERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_THR_WRITE: assert property (
      (wr_ok && aw_addr == CST_ADDR_THR)
      |=> threshold_level_two == $past(w_data))
      else $error("threshold write not stored");
   AST_THR_HOLD: assert property (
      !(wr_ok && aw_addr == CST_ADDR_THR) |=> $stable(threshold_level_two))
      else $error("threshold code moved without a write");
   AST_DAC_SAME: assert property (
      (wr_ok && aw_addr == CST_ADDR_THR) |=> dac_level == $past(w_data))
      else $error("dac output level does not follow threshold write");
   AST_FLAG_SET: assert property (
      (cmp_enable[0] && live[0] != live_d[0]) |=> flags[0])
      else $error("toggle on enabled comparator did not set flag");
   AST_FLAG_STICKY: assert property (
      (flags[1] && !(wr_ok && aw_addr == CST_ADDR_STAT && w_data[5]))
      |=> flags[1])
      else $error("flag cleared without a software write");
   AST_FORCE_LOW: assert property (
      (!cmp_enable[2] && $past(!cmp_enable[2])) |-> !live[2])
      else $error("disabled comparator shows a live output");
   AST_IRQ_GATE: assert property (
      ((flags & irq_allow) == '0) |=> !irq)
      else $error("interrupt raised for a disallowed comparator");
   AST_IRQ_RISE: assert property (
      (|(flags & irq_allow)) |=> irq)
      else $error("allowed flag did not raise the interrupt");
   AST_STATUS_READ: assert property (
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == CST_ADDR_STAT)
      |=> s_axi_rvalid ##0 s_axi_rdata[CST_REG_W-1:0] == $past(status_view))
      else $error("status read returned wrong contents");
   AST_FILT_WRITE: assert property (
      (wr_ok && aw_addr == CST_ADDR_STAT)
      |=> filter_on == $past(w_data[CST_LIVE_HI:CST_LIVE_LO]))
      else $error("filter enables not taken from status write");
   AST_FLAG_CLEAR: assert property (
      (flag_clr[3] && !flag_set[3]) |=> !flags[3])
      else $error("written one did not clear the flag");
   AST_SET_WINS: assert property (
      (flag_set[2] && flag_clr[2]) |=> flags[2])
      else $error("toggle lost to a clear in the same cycle");
   AST_NO_FLAG_OFF: assert property (
      (!cmp_enable[1] && !flags[1]) |=> !flags[1])
      else $error("disabled comparator raised its flag");

   // -------------------------------------------------------------
   // bus protocol checks
   // -------------------------------------------------------------
   AST_B_ANSWER: assert property (
      wr_fire |=> s_axi_bvalid)
      else $error("write response missing after write performed");
   AST_B_HOLD: assert property (
      (s_axi_bvalid && !s_axi_bready)
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
   AST_B_DECERR: assert property (
      (wr_fire && !wr_mapped) |=> s_axi_bresp == CST_RESP_DECERR)
      else $error("unmapped write not answered with decode error");
   AST_WR_QUIET: assert property (
      !wr_ok |=> $stable(irq_allow) && $stable(cmp_enable))
      else $error("control register moved without a write");
   AST_R_ANSWER: assert property (
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
      else $error("read data missing after address taken");
   AST_R_HOLD: assert property (
      (s_axi_rvalid && !s_axi_rready)
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data changed before rready");
   AST_RD_DECERR: assert property (
      (s_axi_arvalid && s_axi_arready
      && s_axi_araddr != CST_ADDR_THR && s_axi_araddr != CST_ADDR_STAT
      && s_axi_araddr != CST_ADDR_CTRL && s_axi_araddr != CST_ADDR_MASK)
      |=> s_axi_rresp == CST_RESP_DECERR)
      else $error("unmapped read not answered with decode error");

   COV_FLAG: cover property ($rose(flags[0]));
   COV_IRQ: cover property ($rose(irq));
   COV_THR: cover property (wr_ok && aw_addr == CST_ADDR_THR);
   COV_CLR: cover property (flags[3] ##1 !flags[3]);
   COV_DECERR: cover property (
      s_axi_bvalid && s_axi_bresp == CST_RESP_DECERR);
endmodule : cst_top

// ==== verification/cst_analog_model.sv ====
// behavioural model of the four analog comparators and threshold dac
`timescale 1ns/100ps
module cst_analog_model import cst_pkg::*; (
   // clock
   input wire logic aclk,
   // controls from the block
   input wire logic [CST_NCMP-1:0] cmp_enable,
   input wire logic [CST_REG_W-1:0] threshold_level_two,
   input wire logic [CST_REG_W-1:0] dac_level,
   // analog inputs in millivolts, from the bench
   input wire logic [CST_NCMP-1:0][15:0] vin_mv,
   // comparator outputs and dac voltage
   output logic [CST_NCMP-1:0] cmp_raw,
   output int dac_mv
);
   // ----------------------------------------------------------
   // threshold and dac voltage
   // ----------------------------------------------------------
   int thr_mv;
   logic [CST_NCMP-1:0] junk = '0;
   assign thr_mv = int'(threshold_level_two) * 1500 / 255;
   assign dac_mv = int'(dac_level) * 1500 / 255;
   // a powered-down comparator gives no defined level: keep it moving
   always_ff @(posedge aclk) begin
      junk <= ~junk;
   end
   always_comb begin
      for (int i = 0; i < CST_NCMP; i++) begin
         cmp_raw[i] = cmp_enable[i] ? (int'(vin_mv[i]) > thr_mv) : junk[i];
      end
   end
endmodule : cst_analog_model

// ==== verification/cst_top_bench.sv ====
// self-checking bench for the comparator status and threshold block
`timescale 1ns/100ps
module cst_top_bench import cst_pkg::*;;
   // ----------------------------------------------------------
   // signals
   // ----------------------------------------------------------
   typedef struct {
      logic [17:0] a;
      logic [7:0] d;
      logic [3:0] s;
      logic [7:0] e;
      logic [1:0] r;
   } cst_row_t;
   cst_row_t rows [8];
   logic aclk = 0;
   logic aresetn = 0;
   logic [CST_ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [31:0] wdata = '0, rdata, got;
   logic [3:0] wstrb = 4'hF, cmp_raw, cmp_enable;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] thr, dacl;
   logic [3:0][15:0] vin_mv = '0;
   int dac_mv;
   int bad_count = 0;
   int check_count = 0;
   localparam logic [3:0][15:0] HIGH = {4{16'h03E8}};

   cst_top uut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .cmp_raw(cmp_raw), .cmp_enable(cmp_enable),
      .threshold_level_two(thr), .dac_level(dacl), .irq(irq)
   );
   cst_analog_model model (
      .aclk(aclk), .cmp_enable(cmp_enable), .threshold_level_two(thr),
      .dac_level(dacl), .vin_mv(vin_mv), .cmp_raw(cmp_raw),
      .dac_mv(dac_mv)
   );

   initial begin
      forever #20 aclk = ~aclk;
   end
   // ----------------------------------------------------------
   // tasks
   // ----------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] seen);
      check_count++;
      if (seen !== e) begin
         bad_count++;
         $display("mismatch %s expected %0h seen %0h", what, e, seen);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask : tick
   // both channels offered together; bready held until the answer
   task automatic wr(input logic [17:0] a, input logic [7:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) break;
      end
      bready <= 1'b0;
      resp = bresp;
      if (n == 50) begin
         chk("write timeout", 0, 1);
         tally_and_finish();
      end
   endtask : wr
   task automatic rd(input logic [17:0] a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) break;
      end
      rready <= 1'b0;
      resp = rresp;
      got = rdata;
      if (n == 50) begin
         chk("read timeout", 0, 1);
         tally_and_finish();
      end
   endtask : rd
   task automatic stat(input string what, input logic [7:0] e);
      rd(CST_ADDR_STAT);
      chk(what, {24'h0, e}, got);
   endtask : stat
   // ----------------------------------------------------------
   // sequence
   // ----------------------------------------------------------
   initial begin
      rows = '{
         '{CST_ADDR_THR, 8'hA5, 4'hF, 8'hA5, CST_RESP_OKAY},
         '{CST_ADDR_THR, 8'h3C, 4'h0, 8'hA5, CST_RESP_OKAY},
         '{CST_ADDR_MASK, 8'hFF, 4'hF, 8'hF0, CST_RESP_OKAY},
         '{CST_ADDR_MASK, 8'h00, 4'hF, 8'h00, CST_RESP_OKAY},
         '{CST_ADDR_CTRL, 8'hA0, 4'hF, 8'hA0, CST_RESP_OKAY},
         '{CST_ADDR_CTRL, 8'h00, 4'hF, 8'h00, CST_RESP_OKAY},
         '{18'h28108, 8'h55, 4'hF, 8'h00, CST_RESP_DECERR},
         '{CST_ADDR_THR, 8'h80, 4'hF, 8'h80, CST_RESP_OKAY}};
      tick(10);
      aresetn <= 1'b1;
      chk("irq after reset", 0, irq);
      rd(CST_ADDR_THR);
      chk("threshold reset", 0, got);
      stat("status reset", 8'h00);
      foreach (rows[i]) begin
         wstrb <= rows[i].s;
         wr(rows[i].a, rows[i].d);
         chk("write resp", 32'(rows[i].r), 32'(resp));
         rd(rows[i].a);
         chk("read resp", 32'(rows[i].r), 32'(resp));
         if (rows[i].r == CST_RESP_OKAY) begin
            chk("read data", {24'h0, rows[i].e}, got);
         end
      end
      wstrb <= 4'hF;
      chk("dac code", 32'h80, 32'(dacl));
      chk("threshold out", 32'h80, 32'(thr));
      chk("dac mv", 752, dac_mv);
      // all four enabled above threshold: live and flags up
      vin_mv <= HIGH;
      wr(CST_ADDR_CTRL, 8'h0F);
      tick(8);
      stat("enable toggle", 8'hFF);
      chk("irq masked", 0, irq);
      wr(CST_ADDR_MASK, 8'h20);
      tick(3);
      chk("irq allowed", 1, irq);
      tick(20);
      stat("flags sticky", 8'hFF);
      wr(CST_ADDR_STAT, 8'hF0);
      stat("flags cleared", 8'h0F);
      tick(3);
      chk("irq cleared", 0, irq);
      wr(CST_ADDR_CTRL, 8'hFF);
      tick(8);
      stat("inverted", 8'hF0);
      // fifteen differing samples must not pass the filter, sixteen must
      wr(CST_ADDR_STAT, 8'hFF);
      vin_mv <= '0;
      tick(15);
      vin_mv <= HIGH;
      tick(12);
      stat("glitch filtered", 8'h00);
      vin_mv <= '0;
      tick(17);
      stat("filter not yet", 8'h00);
      stat("filtered change", 8'hFF);
      wr(CST_ADDR_STAT, 8'hF0);
      wr(CST_ADDR_CTRL, 8'hF0);
      tick(10);
      stat("disabled low", 8'h00);
      chk("enables off", 0, cmp_enable);
      // reset in mid-run returns the registers to zero
      wr(CST_ADDR_THR, 8'h5A);
      aresetn <= 1'b0;
      tick(2);
      aresetn <= 1'b1;
      rd(CST_ADDR_THR);
      chk("threshold mid reset", 0, got);
      rd(CST_ADDR_MASK);
      chk("mask mid reset", 0, got);
      chk("irq mid reset", 0, irq);
      wr(CST_ADDR_THR, 8'h00);
      tally_and_finish();
   end
endmodule : cst_top_bench
